//--- logic/rtv_brk.sv
// breaker interface: two-out-of-three vote, priority and coil drive paths
`timescale 1ns/100ps
module rtv_brk
  import rtv_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [NCOPY-1:0] trip_copy,
  input  wire logic             manual_trip,
  input  wire logic             pcs_open,
  input  wire logic             permissive,
  input  wire logic             trip_reset,
  output logic                  uv_out,
  output logic                  shunt_out,
  output logic                  tripped
);

  rtv_brk_st_t st, next_st;
  logic        auto_trip, demand, pcs_ok, next_energize;

  // ------------------------------------------------------------------
  // priority: manual and automatic first, plant control last
  // ------------------------------------------------------------------
  assign auto_trip = rtv_ones4({1'b0, trip_copy}) >= COPY_NEED;
  // manual switch bypasses the voter entirely, so a dead voter cannot block it
  assign demand = auto_trip | manual_trip;
  assign pcs_ok = permissive & ~demand;
  assign next_energize = (next_st == BRK_ARMED) & ~(pcs_ok & pcs_open);

  // latch: only an explicit reset with demand gone re-arms
  always_comb begin
    next_st = st;
    unique case (st)
      BRK_ARMED:   if (demand) next_st = BRK_TRIPPED;
      BRK_TRIPPED: if (trip_reset && !demand) next_st = BRK_ARMED;
    endcase
  end

  // both paths drop together; either alone opens the breaker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= BRK_TRIPPED;
      uv_out    <= 1'b0;
      shunt_out <= 1'b0;
      tripped   <= 1'b1;
    end else begin
      st        <= next_st;
      uv_out    <= next_energize;
      shunt_out <= next_energize;
      tripped   <= next_st == BRK_TRIPPED;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_manual;
    manual_trip |=> !uv_out && !shunt_out && tripped;
  endproperty
  a_manual: assert property (p_manual) else $error("manual trip ignored");

  property p_two_of_three;
    (rtv_ones4({1'b0, trip_copy}) >= COPY_NEED) |=> !uv_out;
  endproperty
  a_two_of_three: assert property (p_two_of_three) else $error("voted trip ignored");

  property p_paths_agree;
    uv_out == shunt_out;
  endproperty
  a_paths_agree: assert property (p_paths_agree) else $error("coil paths differ");

  property p_latched;
    (tripped && !trip_reset) |=> tripped && !uv_out;
  endproperty
  a_latched: assert property (p_latched) else $error("trip released without reset");

  property p_pcs_gate;
    (pcs_open && !permissive) ##1 (tripped == 1'b0 && $past(tripped) == 1'b0) |-> uv_out;
  endproperty
  a_pcs_gate: assert property (p_pcs_gate) else $error("plant control acted without permissive");

endmodule

//--- logic/rtv_division.sv
// one division of trip voting, actuation priority and maintenance access
// Function
// - Voter takes four group trip inputs
// - Trip when two of four vote
// - Breaker trips on two of three copies
// - Separate undervoltage and shunt drive paths
// - Trip drops both coil outputs together
// - One breaker per parallel path
// - Priority logic takes three command sources
// - Highest priority command drives each breaker
// - Manual trip always works, voter regardless
// - Plant control needs permissive, no demand
// - Manual switch bypasses digital processing; here it skips only the voter, and rtv_brk still latches and flops it
// - Breaker and bus status go to maintenance
// - Parameter change needs out-of-service and link
// - Maintenance link reaches one group only
// - Maintenance module per group and division
// - Divisional maintenance refuses parameter changes
// - Three 24-hour monitoring timers per division
`timescale 1ns/100ps
module rtv_division
  import rtv_pkg::*;
#(
  parameter longint PAM_CYCLES = PAM_CYCLES_DF
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NGRP-1:0] grp_trip,
  input  wire logic [NGRP-1:0] grp_valid,
  input  wire logic            manual_trip,
  input  wire logic [NBRK-1:0] pcs_open,
  input  wire logic            nonsafety_permissive,
  input  wire logic [NBRK-1:0] brk_status,
  input  wire logic [3:0]      sdb_status,
  output logic      [NBRK-1:0] uv_out,
  output logic      [NBRK-1:0] shunt_out,
  output logic                 div_trip,
  output logic      [7:0]      maint_bus_status,
  output logic                 pam_only
);

  localparam logic [TMR_W-1:0] PAM_LAST = TMR_W'(PAM_CYCLES - 1);

  // ------------------------------------------------------------------
  // voting and breaker interfaces
  // ------------------------------------------------------------------
  logic [NGRP-1:0]  votes;
  logic [NCOPY-1:0] trip_copy;
  logic [NBRK-1:0]  brk_tripped;
  logic             trip_reset;

  // group trips arrive from every group; both divisions see the same set
  rtv_vote u_vote (
    .pclk      (pclk),
    .presetn   (presetn),
    .grp_trip  (grp_trip),
    .grp_valid (grp_valid),
    .votes     (votes),
    .trip      (trip_copy)
  );

  // one breaker in each parallel path, each fed all three copies
  generate
    for (genvar b = 0; b < NBRK; b++) begin : g_brk
      rtv_brk u_brk (
        .pclk        (pclk),
        .presetn     (presetn),
        .trip_copy   (trip_copy),
        .manual_trip (manual_trip),
        .pcs_open    (pcs_open[b]),
        .permissive  (nonsafety_permissive),
        .trip_reset  (trip_reset),
        .uv_out      (uv_out[b]),
        .shunt_out   (shunt_out[b]),
        .tripped     (brk_tripped[b])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic        conn, divtgt;
  logic [1:0]  grp;
  logic [3:0]  oos;
  logic [31:0] param;
  logic [7:0]  reject_cnt;
  logic [NTMR-1:0] tdone;
  logic        acc, fire, wr_ok;
  logic        a_ctrl, a_stat, a_maint, a_param, a_tmr, mapped;
  logic        param_ok, maint_ok, err;
  logic        next_pready;
  logic [31:0] rdata;
  logic [NTMR-1:0] tstart;

  assign acc      = psel & penable;
  assign fire     = acc & pready;
  assign a_ctrl   = paddr == ADDR_CTRL;
  assign a_stat   = paddr == ADDR_STAT;
  assign a_maint  = paddr == ADDR_MAINT;
  assign a_param  = paddr == ADDR_PARAM;
  assign a_tmr    = paddr == ADDR_TIMER;
  assign mapped   = a_ctrl | a_stat | a_maint | a_param | a_tmr;
  // calibration lands only with link up, the selected group out of service and divtgt clear
  assign param_ok = conn & oos[grp] & ~divtgt;
  // while linked, the selected group cannot be swapped for another
  assign maint_ok = ~conn | ~pwdata[MAINT_CONN_BIT] | (pwdata[MAINT_GRP_LSB +: 2] == grp);
  assign err      = ~mapped | (pwrite & (a_stat | a_tmr)) | (pwrite & a_param & ~param_ok)
                  | (pwrite & a_maint & ~maint_ok);
  assign wr_ok    = fire & pwrite & ~err;
  // one wait cycle, so every answer comes from a flip-flop
  assign next_pready = acc & ~pready;
  assign tstart   = (wr_ok & a_ctrl) ? pwdata[CTRL_TSTART_LSB +: NTMR] : '0;

  // read mux; status words collect live state for the maintenance side
  assign rdata = a_stat  ? {6'h00, reject_cnt, sdb_status, brk_status, brk_tripped,
                            uv_out, shunt_out, div_trip, 1'b0, votes} :
                 a_maint ? {24'h0, divtgt, oos, grp, conn} :
                 a_param ? param :
                 a_tmr   ? {28'h0, pam_only, tdone} :
                 32'h0;

  // ------------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pready & err;
      prdata  <= (next_pready & ~pwrite) ? rdata : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // maintenance registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn   <= MAINT_RST[MAINT_CONN_BIT];
      grp    <= MAINT_RST[MAINT_GRP_LSB +: 2];
      oos    <= MAINT_RST[MAINT_OOS_LSB +: 4];
      divtgt <= MAINT_RST[MAINT_DIV_BIT];
    end else if (wr_ok && a_maint) begin
      conn   <= pwdata[MAINT_CONN_BIT];
      grp    <= pwdata[MAINT_GRP_LSB +: 2];
      oos    <= pwdata[MAINT_OOS_LSB +: 4];
      divtgt <= pwdata[MAINT_DIV_BIT];
    end
  end

  // parameter store; refused writes only bump the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param      <= PARAM_RST;
      reject_cnt <= 8'h00;
    end else begin
      if (wr_ok && a_param) begin
        param <= pwdata;
      end
      if (fire && pwrite && err && reject_cnt != 8'hff) begin
        reject_cnt <= reject_cnt + 8'h01;
      end
    end
  end

  // trip reset is a one-cycle pulse from a control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reset <= 1'b0;
    end else begin
      trip_reset <= wr_ok & a_ctrl & pwdata[CTRL_RST_BIT];
    end
  end

  // ------------------------------------------------------------------
  // monitoring-only timers
  // ------------------------------------------------------------------
  generate
    for (genvar t = 0; t < NTMR; t++) begin : g_tmr
      logic             run, done, expire;
      logic [TMR_W-1:0] cnt;
      assign expire = run & (cnt == PAM_LAST);
      // restart clears done, but an expiry in the same cycle still sets it; done holds until restarted
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run  <= 1'b0;
          done <= 1'b0;
          cnt  <= '0;
        end else if (tstart[t]) begin
          run  <= 1'b1;
          done <= expire;
          cnt  <= '0;
        end else if (expire) begin
          run  <= 1'b0;
          done <= 1'b1;
        end else if (run) begin
          cnt  <= cnt + TMR_W'(1);
        end
      end
      assign tdone[t] = done;
    end
  endgenerate

  // ------------------------------------------------------------------
  // outputs toward the maintenance bus and the division
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_bus_status <= 8'h00;
      div_trip         <= 1'b1;
      pam_only         <= 1'b0;
    end else begin
      maint_bus_status <= {sdb_status, brk_status, uv_out};
      div_trip         <= trip_copy[0];
      pam_only         <= |tdone;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable;
  endsequence

  property p_answer;
    s_setup ##1 s_access |-> !pready ##1 pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not after one wait");

  property p_param_guard;
    (fire && pwrite && a_param && !(conn && oos[grp] && !divtgt)) |-> pslverr ##1 $stable(param);
  endproperty
  a_param_guard: assert property (p_param_guard) else $error("parameter write not refused");

  property p_div_refuse;
    (fire && pwrite && a_param && divtgt) |-> pslverr;
  endproperty
  a_div_refuse: assert property (p_div_refuse) else $error("divisional calibration accepted");

  property p_one_group;
    (conn && fire && pwrite && a_maint && pwdata[MAINT_CONN_BIT]
     && pwdata[MAINT_GRP_LSB +: 2] != grp) |=> $stable(grp) && conn;
  endproperty
  a_one_group: assert property (p_one_group) else $error("group switched while linked");

  property p_status_fwd;
    ##1 (maint_bus_status == {$past(sdb_status), $past(brk_status), $past(uv_out)});
  endproperty
  a_status_fwd: assert property (p_status_fwd) else $error("status not forwarded");

  property p_division_trip;
    manual_trip ##1 !manual_trip |-> (uv_out == 2'b00) && (shunt_out == 2'b00);
  endproperty
  a_division_trip: assert property (p_division_trip) else $error("division did not open breakers");

  // bus answer and register landing
  property p_read_param;
    (s_access && !pwrite && a_param && !pready) |=> (prdata == param);
  endproperty
  a_read_param: assert property (p_read_param) else $error("parameter read data wrong");

  property p_read_idle;
    !pready |-> (prdata == 32'h0);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside answer cycle");

  property p_param_lands;
    (fire && pwrite && a_param && !err) |=> (param == $past(pwdata));
  endproperty
  a_param_lands: assert property (p_param_lands) else $error("accepted parameter write lost");

  property p_maint_lands;
    (fire && pwrite && a_maint && !err) |=> ({divtgt, oos, grp, conn} == $past(pwdata[7:0]));
  endproperty
  a_maint_lands: assert property (p_maint_lands) else $error("accepted maintenance write lost");

  property p_reject_count;
    (fire && pwrite && err && (reject_cnt != 8'hff)) |=> (reject_cnt == $past(reject_cnt) + 8'h01);
  endproperty
  a_reject_count: assert property (p_reject_count) else $error("refused write not counted");

  property p_read_votes;
    (s_access && !pwrite && a_stat && !pready) |=> (prdata[3:0] == $past(votes));
  endproperty
  a_read_votes: assert property (p_read_votes) else $error("status read lost the votes");

  // trip latch, timers and vote sync
  property p_reset_pulse;
    trip_reset |=> !trip_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("trip reset longer than one cycle");

  property p_rearm_refused;
    (trip_reset && ((trip_copy == 3'h7) || manual_trip)) |=> (uv_out == 2'b00) && (shunt_out == 2'b00);
  endproperty
  a_rearm_refused: assert property (p_rearm_refused) else $error("breaker re-armed under demand");

  property p_div_trip_follow;
    ##1 (div_trip == $past(trip_copy[0]));
  endproperty
  a_div_trip_follow: assert property (p_div_trip_follow) else $error("division trip output stale");

  property p_pam_any;
    ##1 (pam_only == $past(|tdone));
  endproperty
  a_pam_any: assert property (p_pam_any) else $error("monitoring-only flag wrong");

  property p_done_sticky;
    ((tdone != 3'h0) && (tstart == 3'h0)) |=> ((tdone & $past(tdone)) == $past(tdone));
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("timer done dropped without restart");

  property p_invalid_trip;
    (grp_valid == 4'h0) |-> ##3 (votes == 4'hf);
  endproperty
  a_invalid_trip: assert property (p_invalid_trip) else $error("invalid groups did not vote trip");

endmodule

//--- logic/rtv_pkg.sv
// shared constants, register map and helpers for the divisional trip logic
package rtv_pkg;

  // ------------------------------------------------------------------
  // structure
  // ------------------------------------------------------------------
  localparam int NGRP  = 4;
  localparam int NCOPY = 3;
  localparam int NBRK  = 2;
  localparam int NTMR  = 3;
  localparam logic [2:0] VOTE_NEED = 3'h2;
  localparam logic [2:0] COPY_NEED = 3'h2;

  // ------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_MAINT = 8'h08;
  localparam logic [7:0] ADDR_PARAM = 8'h0c;
  localparam logic [7:0] ADDR_TIMER = 8'h10;
  localparam int CTRL_RST_BIT    = 0;
  localparam int CTRL_TSTART_LSB = 1;
  localparam int MAINT_CONN_BIT  = 0;
  localparam int MAINT_GRP_LSB   = 1;
  localparam int MAINT_OOS_LSB   = 3;
  localparam int MAINT_DIV_BIT   = 7;
  localparam logic [31:0] PARAM_RST = 32'h0;
  localparam logic [7:0]  MAINT_RST = 8'h00;

  // ------------------------------------------------------------------
  // timing: 24 h monitoring timers at 25 MHz
  // ------------------------------------------------------------------
  localparam longint PAM_HOURS     = 24;
  localparam longint SEC_PER_HOUR  = 3600;
  localparam longint CLK_HZ        = 25000000;
  localparam longint PAM_CYCLES_DF = PAM_HOURS * SEC_PER_HOUR * CLK_HZ;
  localparam int     TMR_W         = 42;

  typedef enum {BRK_ARMED, BRK_TRIPPED} rtv_brk_st_t;

  // number of set bits in a four-bit vote word
  function automatic logic [2:0] rtv_ones4(input logic [3:0] v);
    rtv_ones4 = 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]});
  endfunction

endpackage

//--- logic/rtv_vote.sv
// two-out-of-four coincidence voter with input synchronisers
`timescale 1ns/100ps
module rtv_vote
  import rtv_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [NGRP-1:0]  grp_trip,
  input  wire logic [NGRP-1:0]  grp_valid,
  output logic      [NGRP-1:0]  votes,
  output logic      [NCOPY-1:0] trip
);

  logic [NGRP-1:0] s1_trip, s1_valid, s2_trip, s2_valid;
  logic [NGRP-1:0] next_votes;

  // missing or invalid group counts as a trip vote
  assign next_votes = s2_trip | ~s2_valid;

  // two stages, then vote; reset leaves every group invalid, so all vote trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_trip  <= '0;
      s1_valid <= '0;
      s2_trip  <= '0;
      s2_valid <= '0;
      votes    <= '1;
      trip     <= '1;
    end else begin
      s1_trip  <= grp_trip;
      s1_valid <= grp_valid;
      s2_trip  <= s1_trip;
      s2_valid <= s1_valid;
      votes    <= next_votes;
      trip     <= {NCOPY{rtv_ones4(next_votes) >= VOTE_NEED}};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_coincide;
    (rtv_ones4(s2_trip | ~s2_valid) >= VOTE_NEED) |=> (trip == 3'h7);
  endproperty
  a_coincide: assert property (p_coincide) else $error("two votes did not trip");

  property p_single_vote;
    (grp_valid == 4'hf && rtv_ones4(grp_trip) < VOTE_NEED) [*3] |=> (trip == 3'h0);
  endproperty
  a_single_vote: assert property (p_single_vote) else $error("trip without coincidence");

endmodule

//--- tb/rtv_grp_model.sv
// behavioural model of the separation-group trip senders and the division manual switch
`timescale 1ns/100ps
module rtv_grp_model
  import rtv_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [NGRP-1:0] trip_cmd,
  input  wire logic [NGRP-1:0] fail_cmd,
  input  wire logic            switch_cmd,
  output logic      [NGRP-1:0] grp_trip,
  output logic      [NGRP-1:0] grp_valid,
  output logic                 manual_trip
);
  // ----------------------------------------------------------------
  // group senders
  // ----------------------------------------------------------------
  // a failed group drops valid and its trip line wanders, so stale data never looks good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_trip  <= '0;
      grp_valid <= '0;
    end else begin
      grp_trip  <= (trip_cmd & ~fail_cmd) | (~grp_trip & fail_cmd);
      grp_valid <= ~fail_cmd;
    end
  end

  // one switch for this division only; flopped so it moves just after an edge
  always_ff @(posedge pclk) begin
    manual_trip <= switch_cmd;
  end
endmodule

//--- tb/tb_reactor_trip_voting_priority.sv
// self-checking bench for one division of trip voting, priority and maintenance access
`timescale 1ns/100ps
module tb_reactor_trip_voting_priority
  import rtv_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, maint_bus_status;
  logic [31:0]     pwdata, prdata, r;
  logic [NGRP-1:0] grp_trip, grp_valid, trip_cmd, fail_cmd;
  logic [NBRK-1:0] pcs_open, brk_status, uv_out, shunt_out;
  logic            manual_trip, switch_cmd, nonsafety_permissive, div_trip, pam_only;
  logic [3:0]      sdb_status;
  int              err_total, checks;

  // short timer length keeps the run small
  rtv_division #(.PAM_CYCLES(20)) u_rtv_division (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .grp_trip(grp_trip), .grp_valid(grp_valid), .manual_trip(manual_trip), .pcs_open(pcs_open),
    .nonsafety_permissive(nonsafety_permissive), .brk_status(brk_status), .sdb_status(sdb_status),
    .uv_out(uv_out), .shunt_out(shunt_out), .div_trip(div_trip),
    .maint_bus_status(maint_bus_status), .pam_only(pam_only));

  rtv_grp_model u_rtv_grp_model (
    .pclk(pclk), .presetn(presetn), .trip_cmd(trip_cmd), .fail_cmd(fail_cmd),
    .switch_cmd(switch_cmd), .grp_trip(grp_trip), .grp_valid(grp_valid), .manual_trip(manual_trip));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // settle past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    chk("pready", 32'h1, 32'(pready));
    chk("pslverr", 32'(e), 32'(pslverr));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic out(input logic [1:0] u);
    chk("uv_out", 32'(u), 32'(uv_out));
    chk("shunt_out", 32'(u), 32'(shunt_out));
  endtask

  task automatic wait_uv(input logic [1:0] u);
    int n;
    n = 0;
    while (uv_out !== u && n < 8) begin
      tick(1);
      n++;
    end
    out(u);
  endtask

  // outputs come back one edge after the reset write
  task automatic clear_trip();
    xfer(1'b1, ADDR_CTRL, 32'h1, 1'b0);
    tick(0);
    out(2'b00);
    tick(1);
    out(2'b11);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    out(2'b00);
    chk("pam_only", 32'h0, 32'(pam_only));
    clear_trip();
    $display("test power done");
  endtask

  task automatic t_latency();
    @(posedge pclk);
    trip_cmd <= 4'h3;
    tick(4);
    out(2'b11);
    tick(1);
    out(2'b00);
    chk("div_trip", 32'h1, 32'(div_trip));
    xfer(1'b1, ADDR_CTRL, 32'h1, 1'b0);
    tick(3);
    out(2'b00);
    @(posedge pclk);
    trip_cmd <= 4'h0;
    tick(8);
    out(2'b00);
    clear_trip();
    $display("test latency done");
  endtask

  // every trip pattern, then every invalid pattern
  task automatic t_vote();
    logic [3:0] v;
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      trip_cmd <= (i < 16) ? 4'(i) : 4'h0;
      fail_cmd <= (i < 16) ? 4'h0 : 4'(i);
      v = 4'(i);
      tick(6);
      chk("div_trip", 32'($countones(v) >= 2), 32'(div_trip));
    end
    @(posedge pclk);
    trip_cmd <= 4'h0;
    fail_cmd <= 4'h0;
    tick(6);
    clear_trip();
    $display("test vote done");
  endtask

  task automatic t_manual();
    @(posedge pclk);
    switch_cmd <= 1'b1;
    tick(1);
    out(2'b11);
    tick(1);
    out(2'b00);
    xfer(1'b1, ADDR_CTRL, 32'h1, 1'b0);
    tick(3);
    out(2'b00);
    @(posedge pclk);
    switch_cmd <= 1'b0;
    tick(3);
    clear_trip();
    $display("test manual done");
  endtask

  task automatic t_pcs();
    @(posedge pclk);
    pcs_open <= 2'b01;
    tick(6);
    out(2'b11);
    @(posedge pclk);
    nonsafety_permissive <= 1'b1;
    wait_uv(2'b10);
    @(posedge pclk);
    pcs_open <= 2'b00;
    wait_uv(2'b11);
    @(posedge pclk);
    nonsafety_permissive <= 1'b0;
    $display("test plant control done");
  endtask

  task automatic t_maint();
    @(posedge pclk);
    brk_status <= 2'b01;
    sdb_status <= 4'ha;
    tick(2);
    chk("maint_bus", 32'ha7, 32'(maint_bus_status));
    xfer(1'b0, ADDR_STAT, 32'h0, 1'b0);
    chk("stat", 32'h000293c0, r);
    $display("test status done");
  endtask

  // refused writes leave state alone and are counted
  task automatic t_param();
    xfer(1'b1, ADDR_PARAM, 32'h5a, 1'b1);
    xfer(1'b0, ADDR_PARAM, 32'h0, 1'b0);
    chk("param", 32'h0, r);
    xfer(1'b1, ADDR_MAINT, 32'h25, 1'b0);
    xfer(1'b1, ADDR_PARAM, 32'h5a, 1'b0);
    xfer(1'b1, ADDR_MAINT, 32'h23, 1'b1);
    xfer(1'b0, ADDR_MAINT, 32'h0, 1'b0);
    chk("maint", 32'h25, r);
    xfer(1'b1, ADDR_MAINT, 32'ha5, 1'b0);
    xfer(1'b1, ADDR_PARAM, 32'h33, 1'b1);
    xfer(1'b0, ADDR_PARAM, 32'h0, 1'b0);
    chk("param", 32'h5a, r);
    xfer(1'b1, ADDR_STAT, 32'h1, 1'b1);
    xfer(1'b0, 8'h20, 32'h0, 1'b1);
    xfer(1'b0, ADDR_STAT, 32'h0, 1'b0);
    chk("reject_cnt", 32'h4, (r >> 18) & 32'hff);
    xfer(1'b1, ADDR_MAINT, 32'h0, 1'b0);
    $display("test maintenance done");
  endtask

  task automatic t_timer();
    int n;
    n = 0;
    xfer(1'b0, ADDR_TIMER, 32'h0, 1'b0);
    chk("timer", 32'h0, r);
    xfer(1'b1, ADDR_CTRL, 32'he, 1'b0);
    tick(1);
    chk("pam_only", 32'h0, 32'(pam_only));
    while (pam_only !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("pam_only", 32'h1, 32'(pam_only));
    chk("pam_delay", 32'h1, 32'(n >= 15));
    xfer(1'b0, ADDR_TIMER, 32'h0, 1'b0);
    chk("timer", 32'hf, r);
    $display("test timers done");
  endtask

  // ----------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trip_cmd = 4'h0;
    fail_cmd = 4'h0;
    switch_cmd = 1'b0;
    pcs_open = 2'b00;
    nonsafety_permissive = 1'b0;
    brk_status = 2'b00;
    sdb_status = 4'h0;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    tick(10);
    t_power();
    t_latency();
    t_vote();
    t_manual();
    t_pcs();
    t_maint();
    t_param();
    t_timer();
    stop_test();
  end

  // whole run needs about four hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    stop_test();
  end
endmodule
